// *** src/rsr_pkg.sv ***
package rsr_pkg;
    // ring status word bit positions
    localparam int RS_SIG_LOSS = 0;
    localparam int RS_HARD_ERR = 1;
    localparam int RS_SOFT_ERR = 2;
    localparam int RS_TX_BEACON = 3;
    localparam int RS_LOBE_FAULT = 4;
    localparam int RS_AUTO_REM = 5;
    localparam int RS_REMOVE_RX = 7;
    localparam int RS_CNT_OVF = 8;
    localparam int RS_SINGLE = 9;
    localparam int RS_RECOVERY = 10;
    localparam logic [15:0] RS_LIVE_MASK = 16'h07BF;
    // adapter check word bit positions
    localparam int AC_RING_OVR = 11;
    localparam int AC_BAD_INT = 12;
    localparam int AC_BAD_ERR_INT = 13;
    localparam int AC_BAD_XOP = 14;
    // status block command codes
    localparam logic [15:0] CMD_REJECT = 16'h0002;
    localparam logic [15:0] CMD_RING_STATUS = 16'h0001;
    // indirect address of the check block
    localparam logic [15:0] CHECK_ADDR = 16'h05E0;
    localparam logic [15:0] CHECK_BYTES = 16'h0008;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    // counter threshold for overflow reporting
    localparam logic [7:0] CNT_PRE_MAX = 8'hFE;

    // ring events from the protocol engine
    typedef struct packed {
        logic sig_loss;
        logic beacon_rx;
        logic beacon_tx;
        logic soft_err_sent;
        logic lobe_fault;
        logic auto_rem_err;
        logic remove_rx;
        logic single_on;
        logic station_joined;
        logic claim_active;
        logic purge_rx;
    } rsr_ring_ev_t;

    // internal adapter check events
    typedef struct packed {
        logic ring_overrun;
        logic bad_int;
        logic bad_err_int;
        logic bad_xop;
        logic [15:0] reg0;
        logic [15:0] reg1;
        logic [15:0] reg2;
    } rsr_check_ev_t;

    // one status block write, four words
    typedef struct packed {
        logic [15:0] cmd;
        logic [15:0] stat0;
        logic [15:0] stat1;
        logic [15:0] stat2;
    } rsr_block_t;

    // host status block post engine states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WRITE,
        ST_WAIT_CLEAR
    } rsr_state_t;
endpackage

// *** src/rsr_ring_status_unit.sv ***
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - a ring error event posts the ring status word and interrupts the host.
// - hard-error disable option suppresses beacon-caused ring status interrupts.
// - soft-error disable option suppresses error-report-frame ring status interrupts.
// - signal loss on the ring sets bit 0.
// - bit 1 stays high while beacon frames are sent or received.
// - bit 2 sets after an error report frame was sent.
// - bit 3 stays high while this station sends beacons.
// - lobe fault sets bit 4, closes, returns to command wait.
// - auto-removal hardware error sets bit 5, leaves ring, closes.
// - a host counter stepping 254 to 255 sets bit 8.
// - bit 9 high while sole station, cleared when another inserts.
// - bit 10 set by claim token traffic, cleared by ring purge.
// - bits 11 to 15 read zero; bit 6 has no meaning.
// - invalid command or address posts a rejection with code 0002.
// - a rejection carries the offending command code.
// - address 05E0 then eight auto-increment byte reads return check data.
// - receive DMA overrun sets check bit 11.
// - unknown internal interrupt sets check bit 12 and saves registers.
// - unknown error interrupt sets check bit 13 and saves registers.
// - unknown extended operation request sets check bit 14; bit 15 reserved.
// - every posting writes all four words of the status block.
module rsr_ring_status_unit (
    // clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // ring side events and open options
    input wire rsr_pkg::rsr_ring_ev_t ring_ev_i,
    input wire logic cnt_wrap_i,
    input wire logic [7:0] cnt_val_i,
    input wire logic opt_no_hard_i,
    input wire logic opt_no_soft_i,
    // command block checker
    input wire logic cmd_bad_i,
    input wire logic [15:0] cmd_code_i,
    input wire logic [15:0] cmd_reason_i,
    // adapter check events
    input wire rsr_pkg::rsr_check_ev_t check_ev_i,
    // host status block writer, one word a cycle
    output logic blk_we_o,
    output logic [1:0] blk_idx_o,
    output logic [15:0] blk_data_o,
    output logic host_irq_o,
    input wire logic blk_clear_i,
    // indirect address and auto-increment data port
    input wire logic addr_we_i,
    input wire logic [15:0] addr_wdata_i,
    input wire logic data_rd_i,
    output logic [7:0] data_rdata_o,
    // adapter state
    output logic closed_o,
    output logic [15:0] ring_status_o,
    output logic [15:0] adapter_check_o
);
    rsr_pkg::rsr_state_t state_ff, nxt_state;
    logic [15:0] ring_status_ff, nxt_ring_status;
    logic [15:0] adapter_check_ff, nxt_adapter_check;
    logic [15:0] prm0_ff, prm1_ff, prm2_ff;
    rsr_pkg::rsr_block_t blk_ff, nxt_blk;
    logic [1:0] idx_ff;
    logic [15:0] data_ff;
    logic we_ff, irq_ff, closed_ff;
    logic pend_ring_ff, pend_rej_ff;
    logic [15:0] rej_code_ff, rej_reason_ff;
    logic [15:0] addr_ff;
    logic [7:0] rdata_ff;

    // ring status flag updates
    wire beacon_any = ring_ev_i.beacon_rx | ring_ev_i.beacon_tx;
    wire cnt_ovf = cnt_wrap_i && (cnt_val_i == rsr_pkg::CNT_PRE_MAX);
    wire closing = ring_ev_i.lobe_fault | ring_ev_i.auto_rem_err | ring_ev_i.remove_rx;
    always_comb begin
        nxt_ring_status = ring_status_ff;
        nxt_ring_status[rsr_pkg::RS_HARD_ERR] = beacon_any;
        nxt_ring_status[rsr_pkg::RS_TX_BEACON] = ring_ev_i.beacon_tx;
        if (ring_ev_i.sig_loss) nxt_ring_status[rsr_pkg::RS_SIG_LOSS] = 1'b1;
        if (ring_ev_i.soft_err_sent) nxt_ring_status[rsr_pkg::RS_SOFT_ERR] = 1'b1;
        if (ring_ev_i.lobe_fault) nxt_ring_status[rsr_pkg::RS_LOBE_FAULT] = 1'b1;
        if (ring_ev_i.auto_rem_err) nxt_ring_status[rsr_pkg::RS_AUTO_REM] = 1'b1;
        if (ring_ev_i.remove_rx) nxt_ring_status[rsr_pkg::RS_REMOVE_RX] = 1'b1;
        if (cnt_ovf) nxt_ring_status[rsr_pkg::RS_CNT_OVF] = 1'b1;
        // sole-station: set wins over a simultaneous join
        if (ring_ev_i.station_joined) nxt_ring_status[rsr_pkg::RS_SINGLE] = 1'b0;
        if (ring_ev_i.single_on) nxt_ring_status[rsr_pkg::RS_SINGLE] = 1'b1;
        if (ring_ev_i.purge_rx) nxt_ring_status[rsr_pkg::RS_RECOVERY] = 1'b0;
        if (ring_ev_i.claim_active) nxt_ring_status[rsr_pkg::RS_RECOVERY] = 1'b1;
        nxt_ring_status = nxt_ring_status & rsr_pkg::RS_LIVE_MASK;
    end

    // which events raise a ring status posting, after the open options
    wire post_hard = ring_ev_i.beacon_rx & ~ring_status_ff[rsr_pkg::RS_HARD_ERR]
        | ring_ev_i.beacon_tx & ~ring_status_ff[rsr_pkg::RS_TX_BEACON];
    wire ring_trig = ring_ev_i.sig_loss | (post_hard & ~opt_no_hard_i)
        | (ring_ev_i.soft_err_sent & ~opt_no_soft_i)
        | closing | cnt_ovf
        | (ring_ev_i.single_on & ~ring_status_ff[rsr_pkg::RS_SINGLE])
        | (ring_ev_i.claim_active & ~ring_status_ff[rsr_pkg::RS_RECOVERY]);

    // adapter check word and saved processor registers
    wire save_regs = check_ev_i.bad_int | check_ev_i.bad_err_int | check_ev_i.bad_xop;
    always_comb begin
        nxt_adapter_check = adapter_check_ff;
        if (check_ev_i.ring_overrun) nxt_adapter_check[rsr_pkg::AC_RING_OVR] = 1'b1;
        if (check_ev_i.bad_int) nxt_adapter_check[rsr_pkg::AC_BAD_INT] = 1'b1;
        if (check_ev_i.bad_err_int) begin
            nxt_adapter_check[rsr_pkg::AC_BAD_ERR_INT] = 1'b1;
        end
        if (check_ev_i.bad_xop) nxt_adapter_check[rsr_pkg::AC_BAD_XOP] = 1'b1;
    end

    // posting engine: rejection first, since the host is blocked on its command
    wire start_rej = pend_rej_ff | cmd_bad_i;
    wire start_ring = pend_ring_ff | ring_trig;
    always_comb begin
        nxt_state = state_ff;
        nxt_blk = blk_ff;
        case (state_ff)
            rsr_pkg::ST_IDLE: begin
                if (start_rej) begin
                    nxt_state = rsr_pkg::ST_WRITE;
                    nxt_blk.cmd = rsr_pkg::CMD_REJECT;
                    nxt_blk.stat0 = pend_rej_ff ? rej_reason_ff : cmd_reason_i;
                    nxt_blk.stat1 = pend_rej_ff ? rej_code_ff : cmd_code_i;
                    nxt_blk.stat2 = rsr_pkg::RESET_WORD;
                end else if (start_ring) begin
                    nxt_state = rsr_pkg::ST_WRITE;
                    nxt_blk.cmd = rsr_pkg::CMD_RING_STATUS;
                    nxt_blk.stat0 = nxt_ring_status;
                    nxt_blk.stat1 = rsr_pkg::RESET_WORD;
                    nxt_blk.stat2 = rsr_pkg::RESET_WORD;
                end
            end
            rsr_pkg::ST_WRITE: begin
                if (idx_ff == 2'd3) nxt_state = rsr_pkg::ST_WAIT_CLEAR;
            end
            rsr_pkg::ST_WAIT_CLEAR: begin
                if (blk_clear_i) nxt_state = rsr_pkg::ST_IDLE;
            end
            default: nxt_state = rsr_pkg::ST_IDLE;
        endcase
    end

    // next block word, registered so the data pins come from a flop
    wire [1:0] nxt_idx = (state_ff == rsr_pkg::ST_WRITE) ? idx_ff + 2'd1 : 2'd0;
    wire [15:0] nxt_word = nxt_idx == 2'd0 ? nxt_blk.cmd : nxt_idx == 2'd1 ? nxt_blk.stat0 :
        nxt_idx == 2'd2 ? nxt_blk.stat1 : nxt_blk.stat2;

    wire taking_rej = (state_ff == rsr_pkg::ST_IDLE) && start_rej;
    wire taking_ring = (state_ff == rsr_pkg::ST_IDLE) && !start_rej && start_ring;
    wire in_check = addr_ff[15:3] == rsr_pkg::CHECK_ADDR[15:3];
    wire [2:0] byte_sel = addr_ff[2:0];
    wire [15:0] check_word = byte_sel[2:1] == 2'd0 ? adapter_check_ff :
        byte_sel[2:1] == 2'd1 ? prm0_ff : byte_sel[2:1] == 2'd2 ? prm1_ff : prm2_ff;
    wire [7:0] check_byte = byte_sel[0] ? check_word[7:0] : check_word[15:8];

    // state, flags and posting words
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_ff <= rsr_pkg::ST_IDLE;
            ring_status_ff <= rsr_pkg::RESET_WORD;
            adapter_check_ff <= rsr_pkg::RESET_WORD;
            blk_ff <= '0;
            idx_ff <= 2'd0;
            data_ff <= rsr_pkg::RESET_WORD;
            we_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            ring_status_ff <= nxt_ring_status;
            adapter_check_ff <= nxt_adapter_check;
            blk_ff <= nxt_blk;
            we_ff <= nxt_state == rsr_pkg::ST_WRITE;
            idx_ff <= nxt_idx;
            data_ff <= nxt_word;
            // interrupt rises once all four words are out, drops on clear
            if (state_ff == rsr_pkg::ST_WRITE && idx_ff == 2'd3) irq_ff <= 1'b1;
            else if (blk_clear_i) irq_ff <= 1'b0;
        end
    end

    // pending requests held while the block is busy
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            pend_ring_ff <= 1'b0;
            pend_rej_ff <= 1'b0;
            rej_code_ff <= rsr_pkg::RESET_WORD;
            rej_reason_ff <= rsr_pkg::RESET_WORD;
        end else begin
            pend_ring_ff <= (pend_ring_ff | ring_trig) & ~taking_ring;
            pend_rej_ff <= (pend_rej_ff | cmd_bad_i) & ~taking_rej;
            if (cmd_bad_i && !pend_rej_ff) begin
                rej_code_ff <= cmd_code_i;
                rej_reason_ff <= cmd_reason_i;
            end
        end
    end

    // close on lobe fault, removal error or remove request; reopening is the host's
    always_ff @(posedge mclk_i) begin
        if (srst_i) closed_ff <= 1'b0;
        else if (closing) closed_ff <= 1'b1;
        else if (cmd_code_i == 16'h0003 && !cmd_bad_i && ring_status_ff == 16'h0000) closed_ff <= 1'b0;
    end

    // saved processor registers for the check parameters
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            prm0_ff <= rsr_pkg::RESET_WORD;
            prm1_ff <= rsr_pkg::RESET_WORD;
            prm2_ff <= rsr_pkg::RESET_WORD;
        end else if (save_regs) begin
            prm0_ff <= check_ev_i.reg0;
            prm1_ff <= check_ev_i.reg1;
            prm2_ff <= check_ev_i.reg2;
        end
    end

    // indirect address with auto-increment after each byte read
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            addr_ff <= rsr_pkg::RESET_WORD;
            rdata_ff <= 8'h00;
        end else begin
            if (addr_we_i) addr_ff <= addr_wdata_i;
            else if (data_rd_i) addr_ff <= addr_ff + 16'h0001;
            if (data_rd_i) rdata_ff <= in_check ? check_byte : 8'h00;
        end
    end

    assign blk_we_o = we_ff;
    assign blk_idx_o = idx_ff;
    assign blk_data_o = data_ff;
    assign host_irq_o = irq_ff;
    assign data_rdata_o = rdata_ff;
    assign closed_o = closed_ff;
    assign ring_status_o = ring_status_ff;
    assign adapter_check_o = adapter_check_ff;

    // reserved ring status bits never show
    reserved_zero_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        ring_status_o[15:11] == 5'h00 && !ring_status_o[6])
        else $error("reserved ring status bits set");
    // signal loss posts within a few cycles
    sig_loss_post_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        ring_ev_i.sig_loss && state_ff == rsr_pkg::ST_IDLE && !cmd_bad_i && !pend_rej_ff
        |=> blk_we_o && blk_idx_o == 2'd0 ##0 blk_data_o == rsr_pkg::CMD_RING_STATUS)
        else $error("signal loss not posted");
    // block write is four consecutive words
    four_words_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        $rose(blk_we_o) |-> blk_we_o[*4] ##1 !blk_we_o)
        else $error("status block not four words");
    // interrupt follows last word
    irq_after_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        blk_we_o && blk_idx_o == 2'd3 |=> host_irq_o)
        else $error("interrupt missing after posting");
    // no new posting while waiting for clear
    hold_clear_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        state_ff == rsr_pkg::ST_WAIT_CLEAR && !blk_clear_i |=> !blk_we_o)
        else $error("posting before clear");
    // beacon follows input
    hard_err_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        beacon_any |=> ring_status_o[rsr_pkg::RS_HARD_ERR])
        else $error("hard error not tracking beacon");
    // lobe fault closes
    lobe_close_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        ring_ev_i.lobe_fault |=> closed_o && ring_status_o[rsr_pkg::RS_LOBE_FAULT])
        else $error("lobe fault did not close");
    // rejection code
    reject_code_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        cmd_bad_i && state_ff == rsr_pkg::ST_IDLE && !pend_rej_ff
        |=> blk_data_o == rsr_pkg::CMD_REJECT ##1 blk_idx_o == 2'd1 ##1 blk_data_o == $past(cmd_code_i, 3))
        else $error("bad rejection posting");

    // ring status flags
    sig_loss_set_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        ring_ev_i.sig_loss |=> ring_status_o[rsr_pkg::RS_SIG_LOSS])
        else $error("signal loss flag missing");
    // soft error flag after error report
    soft_err_set_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        ring_ev_i.soft_err_sent |=> ring_status_o[rsr_pkg::RS_SOFT_ERR])
        else $error("soft error flag missing");
    // transmit beacon flag is live
    tx_beacon_on_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        ring_ev_i.beacon_tx |=> ring_status_o[rsr_pkg::RS_TX_BEACON])
        else $error("beacon transmit flag missing");
    // transmit beacon flag drops with the beacon
    tx_beacon_off_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        !ring_ev_i.beacon_tx |=> !ring_status_o[rsr_pkg::RS_TX_BEACON])
        else $error("beacon transmit flag stuck");
    // hard error flag drops with the beacon
    hard_err_off_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        !beacon_any |=> !ring_status_o[rsr_pkg::RS_HARD_ERR])
        else $error("hard error flag stuck");
    // auto-removal error closes
    auto_rem_close_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        ring_ev_i.auto_rem_err |=> closed_o && ring_status_o[rsr_pkg::RS_AUTO_REM])
        else $error("auto-removal did not close");
    // remove request closes
    remove_close_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        ring_ev_i.remove_rx |=> closed_o && ring_status_o[rsr_pkg::RS_REMOVE_RX])
        else $error("remove request did not close");
    // counter overflow flag
    cnt_ovf_set_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        cnt_ovf |=> ring_status_o[rsr_pkg::RS_CNT_OVF])
        else $error("counter overflow flag missing");
    // sole station flag set
    single_set_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        ring_ev_i.single_on |=> ring_status_o[rsr_pkg::RS_SINGLE])
        else $error("single station flag missing");
    // sole station flag cleared by a join
    single_clear_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        ring_ev_i.station_joined && !ring_ev_i.single_on |=> !ring_status_o[rsr_pkg::RS_SINGLE])
        else $error("single station flag not cleared");
    // recovery flag set by claim traffic
    recovery_set_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        ring_ev_i.claim_active |=> ring_status_o[rsr_pkg::RS_RECOVERY])
        else $error("recovery flag missing");
    // recovery flag cleared by purge
    recovery_clear_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        ring_ev_i.purge_rx && !ring_ev_i.claim_active |=> !ring_status_o[rsr_pkg::RS_RECOVERY])
        else $error("recovery flag not cleared");

    // adapter check flags and saved registers
    overrun_flag_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        check_ev_i.ring_overrun |=> adapter_check_o[rsr_pkg::AC_RING_OVR])
        else $error("ring overrun flag missing");
    // invalid interrupt saves the first register
    bad_int_flag_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        check_ev_i.bad_int |=> adapter_check_o[rsr_pkg::AC_BAD_INT] && prm0_ff == $past(check_ev_i.reg0))
        else $error("invalid interrupt not recorded");
    // invalid error interrupt saves the second register
    bad_err_flag_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        check_ev_i.bad_err_int |=> adapter_check_o[rsr_pkg::AC_BAD_ERR_INT] && prm1_ff == $past(check_ev_i.reg1))
        else $error("invalid error interrupt not recorded");
    // invalid extended operation saves the third register
    bad_xop_flag_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        check_ev_i.bad_xop |=> adapter_check_o[rsr_pkg::AC_BAD_XOP] && prm2_ff == $past(check_ev_i.reg2))
        else $error("invalid extended operation not recorded");
    // reserved check bit never shows
    check_reserved_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        !adapter_check_o[15])
        else $error("reserved check bit set");
endmodule
`default_nettype wire

// *** bench/rsr_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module rsr_host_model (
    // clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // status block writes and interrupt from the unit
    input wire logic blk_we_i,
    input wire logic [1:0] blk_idx_i,
    input wire logic [15:0] blk_data_i,
    input wire logic host_irq_i,
    // clear back to the unit, captured block to the bench
    output logic blk_clear_o,
    output var rsr_pkg::rsr_block_t blk_o,
    output logic blk_vld_o
);
    rsr_pkg::rsr_block_t cap_ff;
    logic irq_ff;
    logic slow_ff;
    logic busy_ff;
    logic [2:0] wait_ff;
    // take the block on the irq rise, clear after a pause that alternates short and long
    always_ff @(posedge mclk_i) begin
        blk_vld_o <= 1'b0;
        blk_clear_o <= 1'b0;
        irq_ff <= host_irq_i;
        if (blk_we_i) begin
            cap_ff[(3 - int'(blk_idx_i)) * 16 +: 16] <= blk_data_i;
        end
        if (srst_i) begin
            slow_ff <= 1'b0;
            busy_ff <= 1'b0;
            wait_ff <= 3'h0;
        end else if (host_irq_i && !irq_ff) begin
            blk_o <= cap_ff;
            blk_vld_o <= 1'b1;
            busy_ff <= 1'b1;
            wait_ff <= slow_ff ? 3'h6 : 3'h1;
            slow_ff <= !slow_ff;
        end else if (busy_ff && wait_ff == 3'h0) begin
            blk_clear_o <= 1'b1;
            busy_ff <= 1'b0;
        end else if (busy_ff) begin
            wait_ff <= wait_ff - 3'h1;
        end
    end
endmodule
`default_nettype wire

// *** bench/rsr_ring_status_unit_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module rsr_ring_status_unit_tb_top;
    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    rsr_pkg::rsr_ring_ev_t ev = '0;
    rsr_pkg::rsr_check_ev_t cev = '0;
    logic wrap = 1'b0, no_hard = 1'b0, no_soft = 1'b0, bad = 1'b0;
    logic addr_we = 1'b0, rd = 1'b0, rd_q = 1'b0;
    logic [7:0] cval = 8'h00;
    logic [15:0] code = 16'h0000, why = 16'h0000, addr = 16'h0000, m, c, r;
    logic blk_we, irq, clr, closed, hv;
    logic [1:0] idx;
    logic [7:0] rdata;
    logic [15:0] bdata, rs, ac;
    logic [63:0] w;
    logic [15:0] bits [5] = '{16'h0001, 16'h0004, 16'h0010, 16'h0020, 16'h0080};
    rsr_pkg::rsr_block_t hb, e;
    rsr_pkg::rsr_block_t bq[$];
    logic [7:0] dq[$];
    int error_cnt = 0, checks = 0, posts = 0, cyc = 0, seed = 21, n, nb;

    always #2 mclk_i = ~mclk_i;

    rsr_ring_status_unit dut (.mclk_i(mclk_i), .srst_i(srst_i), .ring_ev_i(ev),
        .cnt_wrap_i(wrap), .cnt_val_i(cval), .opt_no_hard_i(no_hard), .opt_no_soft_i(no_soft),
        .cmd_bad_i(bad), .cmd_code_i(code), .cmd_reason_i(why), .check_ev_i(cev),
        .blk_we_o(blk_we), .blk_idx_o(idx), .blk_data_o(bdata), .host_irq_o(irq),
        .blk_clear_i(clr), .addr_we_i(addr_we), .addr_wdata_i(addr), .data_rd_i(rd),
        .data_rdata_o(rdata), .closed_o(closed), .ring_status_o(rs), .adapter_check_o(ac));
    rsr_host_model host (.mclk_i(mclk_i), .srst_i(srst_i), .blk_we_i(blk_we),
        .blk_idx_i(idx), .blk_data_i(bdata), .host_irq_i(irq), .blk_clear_o(clr),
        .blk_o(hb), .blk_vld_o(hv));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("counts: %0d mismatches in %0d checks", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic rst(input int k);
        @(posedge mclk_i);
        srst_i <= 1'b1;
        repeat (k) @(posedge mclk_i);
        srst_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    // bounded wait for every noted result, then let the host clear land
    task automatic wq();
        n = 0;
        while ((bq.size() > 0 || dq.size() > 0) && n < 300) begin
            @(posedge mclk_i);
            n++;
        end
        chk(16'(n >= 300), 16'h0000);
        repeat (12) @(posedge mclk_i);
    endtask
    task automatic pulse_ev(input int k);
        @(posedge mclk_i);
        case (k)
            0: ev.sig_loss <= 1'b1;
            1: ev.soft_err_sent <= 1'b1;
            2: ev.lobe_fault <= 1'b1;
            3: ev.auto_rem_err <= 1'b1;
            4: ev.remove_rx <= 1'b1;
            5: ev.single_on <= 1'b1;
            6: ev.station_joined <= 1'b1;
            7: ev.claim_active <= 1'b1;
            default: ev.purge_rx <= 1'b1;
        endcase
        @(posedge mclk_i);
        ev <= '0;
    endtask

    // result watcher: oldest note against each captured block or read byte
    always @(negedge mclk_i) begin
        if (hv) posts++;
        if (hv && bq.size() > 0) begin
            e = bq.pop_front();
            chk(hb.cmd, e.cmd);
            chk(hb.stat0, e.stat0);
            chk(hb.stat1, e.stat1);
            chk(hb.stat2, e.stat2);
        end
        if (rd_q && dq.size() > 0) chk({8'h00, rdata}, {8'h00, dq.pop_front()});
    end
    // read strobe delayed to the cycle where the byte shows, plus the hang limit
    always @(posedge mclk_i) begin
        rd_q <= rd;
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    initial begin
        rst(20);
        chk(rs, 16'h0000);
        chk({ac[15:1], irq}, 16'h0000);
        for (int k = 0; k < 5; k++) begin
            bq.push_back({rsr_pkg::CMD_RING_STATUS, bits[k], 16'h0000, 16'h0000});
            pulse_ev(k);
            wq();
            chk(rs, bits[k]);
            chk(16'(closed), 16'(k > 1));
            rst(1);
            $display("test ring event %0d done", k);
        end
        // live beacon bits, then beacon and error-report postings suppressed
        bq.push_back({rsr_pkg::CMD_RING_STATUS, 16'h000A, 16'h0000, 16'h0000});
        @(posedge mclk_i);
        ev.beacon_tx <= 1'b1;
        wq();
        chk(rs, 16'h000A);
        no_hard <= 1'b1;
        no_soft <= 1'b1;
        ev.beacon_tx <= 1'b0;
        repeat (3) @(posedge mclk_i);
        chk(rs, 16'h0000);
        n = posts;
        ev.beacon_rx <= 1'b1;
        repeat (20) @(posedge mclk_i);
        chk(rs, 16'h0002);
        ev.beacon_rx <= 1'b0;
        pulse_ev(1);
        repeat (20) @(posedge mclk_i);
        chk(rs, 16'h0004);
        chk(16'(posts - n), 16'h0000);
        no_hard <= 1'b0;
        no_soft <= 1'b0;
        $display("test suppression done");
        // counter steps at random values, then the one from FE
        for (int i = 0; i < 21; i++) begin
            @(posedge mclk_i);
            wrap <= 1'b1;
            c = 16'($random(seed));
            cval <= (i == 20) ? rsr_pkg::CNT_PRE_MAX : ((c[7:0] == 8'hFE) ? 8'h00 : c[7:0]);
            @(posedge mclk_i);
            wrap <= 1'b0;
            @(posedge mclk_i);
            chk(rs & 16'h0100, (i == 20) ? 16'h0100 : 16'h0000);
        end
        for (int k = 5; k < 9; k += 2) begin
            m = (k == 5) ? 16'h0200 : 16'h0400;
            pulse_ev(k);
            repeat (2) @(posedge mclk_i);
            chk(rs & m, m);
            pulse_ev(k + 1);
            repeat (2) @(posedge mclk_i);
            chk(rs & (m | 16'hF840), 16'h0000);
        end
        rst(1);
        $display("test counter and state bits done");
        // rejection and ring event on one edge: rejection first, ring posting after clear
        c = 16'($random(seed));
        r = 16'($random(seed));
        bq.push_back({rsr_pkg::CMD_REJECT, r, c, 16'h0000});
        bq.push_back({rsr_pkg::CMD_RING_STATUS, 16'h0001, 16'h0000, 16'h0000});
        @(posedge mclk_i);
        bad <= 1'b1;
        code <= c;
        why <= r;
        ev.sig_loss <= 1'b1;
        @(posedge mclk_i);
        bad <= 1'b0;
        ev <= '0;
        wq();
        rst(1);
        $display("test reject done");
        // each check kind, read through the indirect port, plus one read past the block
        for (int k = 0; k < 4; k++) begin
            m = 16'h0800 << k;
            w = {m, 16'($random(seed)), 16'($random(seed)), 16'($random(seed))};
            nb = (k == 0) ? 2 : 8;
            @(posedge mclk_i);
            cev <= {4'b1000 >> k, w[47:0]};
            @(posedge mclk_i);
            cev <= '0;
            for (int j = 0; j < 2; j++) begin
                @(posedge mclk_i);
                rd <= 1'b0;
                addr_we <= 1'b1;
                addr <= rsr_pkg::CHECK_ADDR + ((j == 1) ? rsr_pkg::CHECK_BYTES : 16'h0000);
                for (int i = 0; i < ((j == 1) ? 1 : nb); i++) begin
                    @(posedge mclk_i);
                    addr_we <= 1'b0;
                    rd <= 1'b1;
                    dq.push_back((j == 1) ? 8'h00 : w[63 - 8 * i -: 8]);
                end
            end
            @(posedge mclk_i);
            rd <= 1'b0;
            wq();
            chk(ac, m);
            rst(1);
            $display("test check kind %0d done", k);
        end
        complete_run();
    end
endmodule
`default_nettype wire
